// File: core/timer_pwm_channels.sv
/*
  Timer core: 16-bit counter with prescaler and modulo, output compare,
  edge- and center-aligned PWM channels, byte registers on classic Wishbone.
  Assumes fixed and external count sources arrive asynchronously on pins
  at no more than a quarter of clock_i.
*/
// The register offsets and register access over Wishbone were decided locally.
// Functional notes
// - compare match sets, clears or toggles the pin per edge/level bits.
// - compare value applies only after both bytes; immediately if clock off.
// - compare value with a clock running applies at next counter step.
// - every compare match sets the channel event flag.
// - edge PWM counts up; period is modulo plus one counts.
// - edge PWM: overflow active, match inactive; select a flips polarity.
// - edge PWM with value zero gives constant 0% duty.
// - edge PWM value above modulo never matches, giving 100% duty.
// - edge PWM value loads as counter steps from top minus one to top.
// - edge PWM coexists with compare channels on the shared up counter.
// - center PWM counts up to modulo then down to zero.
// - center PWM active pulse spans twice the value around zero.
// - center PWM select a low: up match low, down match high.
// - center PWM value zero or bit 15 set gives 0% duty.
// - center PWM positive value above modulo gives 100% duty.
// - modulo and value byte writes go to buffers first.
// - center value loads at once when clock off, else at top step.
// - center mode sets overflow flag at end of the modulo count.
// - control writes discard pending modulo or channel value bytes.
// - reset clears control: clock off, channels capture, pins released.
// - clock select: none, bus clock, fixed clock, external pin.
// - flags clear by read-while-set then write zero; new event wins.
// - center PWM flag sets at both matches of each period.
`timescale 1ns/1ps
`default_nettype none
module timer_pwm_channels #(
  parameter int NCH = 2
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [timer_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [timer_pkg::DATA_W-1:0] wb_dat_i,
  output logic [timer_pkg::DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // asynchronous count sources
  input wire logic fixed_clk_i,
  input wire logic ext_clk_i,
  // channel pins and interrupt
  output logic [NCH-1:0] chan_out_o,
  output logic [NCH-1:0] chan_oe_o,
  output logic irq_o
);
  import timer_pkg::*;

  logic ack_ff;
  logic [7:0] rdat_ff;
  logic irq_ff;
  logic tof_ff, tof_arm_ff, tof_ie_ff, cpwm_ff;
  logic [1:0] clks_ff;
  logic [2:0] ps_ff;
  logic [15:0] cnt_ff, mod_ff, mod_buf_ff;
  logic mod_got_h_ff, mod_got_l_ff;
  logic dir_down_ff, chg_ff;
  logic [6:0] pre_ff;
  logic fix_s1_ff, fix_s2_ff, fix_s3_ff, ext_s1_ff, ext_s2_ff, ext_s3_ff;

  // bus request decode
  wire req = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire wr = wb_cyc_i & wb_stb_i & ack_ff & wb_we_i & wb_sel_i[0]; // ack edge
  wire rd = req & ~wb_we_i;
  wire [7:0] wdat = wb_dat_i[7:0];
  wire wr_tsc = wr & (wb_adr_i == OFS_TSC);
  wire wr_cnt = wr & ((wb_adr_i == OFS_CNTH) | (wb_adr_i == OFS_CNTL));
  wire wr_modh = wr & (wb_adr_i == OFS_MODH);
  wire wr_modl = wr & (wb_adr_i == OFS_MODL);
  wire rd_tsc = rd & (wb_adr_i == OFS_TSC);

  // count source select and prescaler
  wire fix_rise = fix_s2_ff & ~fix_s3_ff;
  wire ext_rise = ext_s2_ff & ~ext_s3_ff;
  wire src_tick = (clks_ff == CLKS_BUS) |
    ((clks_ff == CLKS_FIXED) & fix_rise) |
    ((clks_ff == CLKS_EXT) & ext_rise);
  wire [6:0] pre_mask = 7'((8'h01 << ps_ff) - 8'h01);
  wire pre_done = ((pre_ff & pre_mask) == pre_mask);
  wire cnt_tick = src_tick & pre_done;
  wire clk_off = (clks_ff == CLKS_NONE);

  // counter terminal points
  wire [15:0] top = (mod_ff == MOD_RESET) ? FREE_TOP : mod_ff;
  wire up_top = ~cpwm_ff & (cnt_ff == top);
  wire turn_top = cpwm_ff & ~dir_down_ff & (cnt_ff == mod_ff) &
    (mod_ff != MOD_RESET);
  wire tof_event = cnt_tick & (up_top | turn_top);
  wire pwm_load_pt = cnt_tick & ~dir_down_ff &
    (cnt_ff == top - 16'h0001);
  wire zero_pt = chg_ff & (cnt_ff == CNT_RESET);
  wire mod_full = mod_got_h_ff & mod_got_l_ff;
  wire mod_load = mod_full & (clk_off | cnt_tick);
  wire tof_clr = wr_tsc & ~wdat[TSC_FLAG] & tof_arm_ff;

  logic [15:0] nxt_cnt;
  logic nxt_dir;
  // counter next value: up, or up/down in center mode
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_dir = dir_down_ff;
    if (wr_cnt) begin
      nxt_cnt = CNT_RESET;
      nxt_dir = 1'b0;
    end else if (cnt_tick) begin
      if (up_top) begin
        nxt_cnt = CNT_RESET;
      end else if (turn_top) begin
        nxt_cnt = cnt_ff - 16'h0001;
        nxt_dir = 1'b1;
      end else if (cpwm_ff & dir_down_ff & (cnt_ff == CNT_RESET)) begin
        nxt_cnt = cnt_ff + 16'h0001;
        nxt_dir = 1'b0;
      end else if (cpwm_ff & dir_down_ff) begin
        nxt_cnt = cnt_ff - 16'h0001;
      end else begin
        nxt_cnt = cnt_ff + 16'h0001;
      end
    end
  end

  // synchronisers for the pin count sources
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      {fix_s1_ff, fix_s2_ff, fix_s3_ff} <= 3'h0;
      {ext_s1_ff, ext_s2_ff, ext_s3_ff} <= 3'h0;
    end else begin
      {fix_s1_ff, fix_s2_ff, fix_s3_ff} <= {fixed_clk_i, fix_s1_ff, fix_s2_ff};
      {ext_s1_ff, ext_s2_ff, ext_s3_ff} <= {ext_clk_i, ext_s1_ff, ext_s2_ff};
    end
  end

  // counter, prescaler and overflow flag
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_ff <= CNT_RESET;
      dir_down_ff <= 1'b0;
      chg_ff <= 1'b0;
      pre_ff <= 7'h00;
      tof_ff <= 1'b0;
      tof_arm_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      dir_down_ff <= nxt_dir;
      chg_ff <= cnt_tick | wr_cnt;
      pre_ff <= (wr_cnt | (src_tick & pre_done)) ? 7'h00 :
        (src_tick ? pre_ff + 7'h01 : pre_ff);
      tof_ff <= tof_event | (tof_ff & ~tof_clr);
      tof_arm_ff <= ~tof_event & ~tof_clr &
        (tof_arm_ff | (rd_tsc & tof_ff));
    end
  end

  // timer control and buffered modulo
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tof_ie_ff <= 1'b0;
      cpwm_ff <= 1'b0;
      clks_ff <= CLKS_NONE;
      ps_ff <= 3'h0;
      mod_ff <= MOD_RESET;
      mod_buf_ff <= MOD_RESET;
      mod_got_h_ff <= 1'b0;
      mod_got_l_ff <= 1'b0;
    end else begin
      if (wr_tsc) begin
        tof_ie_ff <= wdat[TSC_IE];
        cpwm_ff <= wdat[TSC_CPWM];
        clks_ff <= wdat[TSC_CLKS_LO +: 2];
        ps_ff <= wdat[TSC_PS_LO +: 3];
      end
      if (wr_modh) mod_buf_ff[15:8] <= wdat;
      if (wr_modl) mod_buf_ff[7:0] <= wdat;
      if (mod_load) mod_ff <= mod_buf_ff;
      // control write cancels a half-written modulo
      if (wr_tsc | mod_load) begin
        mod_got_h_ff <= 1'b0;
        mod_got_l_ff <= 1'b0;
      end else begin
        mod_got_h_ff <= mod_got_h_ff | wr_modh;
        mod_got_l_ff <= mod_got_l_ff | wr_modl;
      end
    end
  end

  // per-channel state gathered for read-back and checks
  chan_mode_t mode_w [NCH];
  logic [15:0] val_w [NCH];
  logic [NCH-1:0] match_w, flag_w, irqv_w, chan_clr_w;
  logic [7:0] rd_or [NCH+1];
  logic [NCH:0] hit_or;
  assign rd_or[0] = RD_UNMAPPED;
  assign hit_or[0] = 1'b0;

  genvar n;
  generate
    for (n = 0; n < NCH; n++) begin : g_ch
      localparam logic [7:0] CB = 8'(OFS_CH_BASE + n * OFS_CH_STRIDE);
      chan_ctrl_t ctrl_ff;
      logic flag_ff, arm_ff, got_h_ff, got_l_ff, out_ff, oe_ff;
      logic [15:0] val_ff, vbuf_ff;
      logic nxt_out;
      // register decode for this channel
      wire sel_csc = (wb_adr_i == CB + OFS_CSC);
      wire sel_cvh = (wb_adr_i == CB + OFS_CVH);
      wire sel_cvl = (wb_adr_i == CB + OFS_CVL);
      wire wr_csc = wr & sel_csc;
      wire wr_cvh = wr & sel_cvh;
      wire wr_cvl = wr & sel_cvl;
      // mode follows center select first, then mode bits
      wire chan_mode_t mode = cpwm_ff ? MODE_CENTER :
        ctrl_ff.msb ? MODE_EDGE :
        ctrl_ff.msa ? MODE_COMPARE : MODE_CAPTURE;
      wire is_pwm = (mode == MODE_EDGE) | (mode == MODE_CENTER);
      wire full = got_h_ff & got_l_ff;
      wire load = full & (clk_off |
        (is_pwm ? pwm_load_pt : cnt_tick));
      wire c_valid = (val_ff != VAL_RESET) & ~val_ff[15];
      wire match = chg_ff & (cnt_ff == val_ff) &
        (mode != MODE_CAPTURE) &
        ((mode != MODE_CENTER) | c_valid);
      wire clr = wr_csc & ~wdat[CSC_FLAG] & arm_ff;
      wire act = ~ctrl_ff.elsa;
      wire [1:0] els = {ctrl_ff.elsb, ctrl_ff.elsa};

      // pin level per mode
      always_comb begin
        nxt_out = out_ff;
        case (mode)
          MODE_COMPARE: begin
            if (match) begin
              case (els)
                2'h1: nxt_out = ~out_ff;
                2'h2: nxt_out = 1'b0;
                2'h3: nxt_out = 1'b1;
                default: nxt_out = out_ff;
              endcase
            end
          end
          MODE_EDGE: begin
            if (match) nxt_out = ~act;
            else if (zero_pt) nxt_out = act;
          end
          MODE_CENTER: begin
            if (!c_valid) nxt_out = ~act;
            else if (match) nxt_out = dir_down_ff ? act : ~act;
            else if (zero_pt) nxt_out = act;
          end
          default: nxt_out = 1'b0;
        endcase
      end

      always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
          ctrl_ff <= CTRL_RESET;
          flag_ff <= 1'b0;
          arm_ff <= 1'b0;
          val_ff <= VAL_RESET;
          vbuf_ff <= VAL_RESET;
          got_h_ff <= 1'b0;
          got_l_ff <= 1'b0;
          out_ff <= 1'b0;
          oe_ff <= 1'b0;
        end else begin
          if (wr_csc) ctrl_ff <= wdat[CSC_IE:CSC_ELSA];
          flag_ff <= match | (flag_ff & ~clr);
          arm_ff <= ~match & ~clr & (arm_ff | (rd & sel_csc & flag_ff));
          if (wr_cvh) vbuf_ff[15:8] <= wdat;
          if (wr_cvl) vbuf_ff[7:0] <= wdat;
          if (load) val_ff <= vbuf_ff;
          if (wr_csc | load) begin
            got_h_ff <= 1'b0;
            got_l_ff <= 1'b0;
          end else begin
            got_h_ff <= got_h_ff | wr_cvh;
            got_l_ff <= got_l_ff | wr_cvl;
          end
          out_ff <= nxt_out;
          oe_ff <= (mode != MODE_CAPTURE) & (els != 2'h0);
        end
      end

      // read-back and shared views
      assign rd_or[n+1] = rd_or[n] |
        (sel_csc ? {flag_ff, ctrl_ff, 2'h0} :
         sel_cvh ? val_ff[15:8] : sel_cvl ? val_ff[7:0] : 8'h00);
      assign hit_or[n+1] = hit_or[n] | sel_csc | sel_cvh | sel_cvl;
      assign mode_w[n] = mode;
      assign val_w[n] = val_ff;
      assign match_w[n] = match;
      assign flag_w[n] = flag_ff;
      assign irqv_w[n] = flag_ff & ctrl_ff.irq_en;
      assign chan_clr_w[n] = clr;
      assign chan_out_o[n] = out_ff;
      assign chan_oe_o[n] = oe_ff;
    end
  endgenerate

  // timer register read mux
  wire [7:0] tmr_rd =
    (wb_adr_i == OFS_TSC) ? {tof_ff, tof_ie_ff, cpwm_ff, clks_ff, ps_ff} :
    (wb_adr_i == OFS_CNTH) ? cnt_ff[15:8] :
    (wb_adr_i == OFS_CNTL) ? cnt_ff[7:0] :
    (wb_adr_i == OFS_MODH) ? mod_ff[15:8] :
    (wb_adr_i == OFS_MODL) ? mod_ff[7:0] : RD_UNMAPPED;

  // bus answer and interrupt request
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_ff <= 1'b0;
      rdat_ff <= RD_UNMAPPED;
      irq_ff <= 1'b0;
    end else begin
      ack_ff <= req;
      if (rd) rdat_ff <= hit_or[NCH] ? rd_or[NCH] : tmr_rd;
      irq_ff <= (tof_ff & tof_ie_ff) | (|irqv_w);
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = {24'h000000, rdat_ff};
  assign irq_o = irq_ff;

  // checks on the channel 0, last-channel toggle and timer behaviour
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  property p_oc_toggle;
    (mode_w[NCH-1] == MODE_COMPARE) && (g_ch[NCH-1].els == 2'h1) &&
      match_w[NCH-1] |=> chan_out_o[NCH-1] != $past(chan_out_o[NCH-1]);
  endproperty
  a_oc_toggle: assert property (p_oc_toggle) else $error("no toggle");
  property p_flag_set;
    match_w[0] |=> flag_w[0];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag unset");
  property p_set_wins;
    match_w[0] && chan_clr_w[0] |=> flag_w[0] ##1 flag_w[0] || match_w[0];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost");
  property p_edge_ovf;
    (mode_w[0] == MODE_EDGE) && zero_pt && !match_w[0]
      |=> chan_out_o[0] == !$past(g_ch[0].ctrl_ff.elsa);
  endproperty
  a_edge_ovf: assert property (p_edge_ovf) else $error("ovf level");
  property p_edge_zero;
    (mode_w[0] == MODE_EDGE) && (val_w[0] == 16'h0000) && zero_pt
      |=> chan_out_o[0] == $past(g_ch[0].ctrl_ff.elsa);
  endproperty
  a_edge_zero: assert property (p_edge_zero) else $error("zero duty");
  property p_center_neg;
    (mode_w[0] == MODE_CENTER) && val_w[0][15] && $stable(val_w[0])
      |=> chan_out_o[0] == $past(g_ch[0].ctrl_ff.elsa);
  endproperty
  a_center_neg: assert property (p_center_neg) else $error("not 0%");
  property p_tof;
    tof_event |=> tof_ff ##1 tof_ff || tof_clr;
  endproperty
  a_tof: assert property (p_tof) else $error("overflow flag lost");
  property p_turn;
    cnt_tick && turn_top && !wr_cnt |=> dir_down_ff &&
      (cnt_ff == $past(mod_ff) - 16'h0001);
  endproperty
  a_turn: assert property (p_turn) else $error("no reversal");
  property p_mod_cancel;
    wr_tsc |=> !mod_got_h_ff && !mod_got_l_ff;
  endproperty
  a_mod_cancel: assert property (p_mod_cancel) else $error("stale");
  property p_pwm_load;
    (mode_w[0] == MODE_EDGE) && !clk_off && $changed(val_w[0]) &&
      $stable(mode_w[0]) |-> $past(pwm_load_pt);
  endproperty
  a_pwm_load: assert property (p_pwm_load) else $error("early load");
  property p_irq;
    (tof_ff && tof_ie_ff) || (|irqv_w) |=> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not raised");
  c_center_cycle: cover property (turn_top && cnt_tick ##[1:300] zero_pt);
  c_edge_match: cover property ((mode_w[0] == MODE_EDGE) && match_w[0]);
  c_flag_clear: cover property (chan_clr_w[0] ##1 !flag_w[0]);
endmodule : timer_pwm_channels
`default_nettype wire

// File: core/timer_pkg.sv
/*
  Shared constants and types for the 16-bit timer with compare/PWM channels.
  Assumes byte-wide registers, each in the low byte of one 32-bit word.
*/
package timer_pkg;
  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // register byte addresses
  localparam logic [7:0] OFS_TSC = 8'h00;
  localparam logic [7:0] OFS_CNTH = 8'h04;
  localparam logic [7:0] OFS_CNTL = 8'h08;
  localparam logic [7:0] OFS_MODH = 8'h0C;
  localparam logic [7:0] OFS_MODL = 8'h10;
  localparam logic [7:0] OFS_CH_BASE = 8'h20;
  localparam logic [7:0] OFS_CH_STRIDE = 8'h10;
  localparam logic [7:0] OFS_CSC = 8'h00;
  localparam logic [7:0] OFS_CVH = 8'h04;
  localparam logic [7:0] OFS_CVL = 8'h08;
  // timer_status_control fields
  localparam int TSC_FLAG = 7;
  localparam int TSC_IE = 6;
  localparam int TSC_CPWM = 5;
  localparam int TSC_CLKS_LO = 3;
  localparam int TSC_PS_LO = 0;
  // channel_status_control fields
  localparam int CSC_FLAG = 7;
  localparam int CSC_IE = 6;
  localparam int CSC_MSB = 5;
  localparam int CSC_MSA = 4;
  localparam int CSC_ELSB = 3;
  localparam int CSC_ELSA = 2;
  // clock_source_select encodings
  localparam logic [1:0] CLKS_NONE = 2'h0;
  localparam logic [1:0] CLKS_BUS = 2'h1;
  localparam logic [1:0] CLKS_FIXED = 2'h2;
  localparam logic [1:0] CLKS_EXT = 2'h3;
  // reset and limit values
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] MOD_RESET = 16'h0000;
  localparam logic [15:0] VAL_RESET = 16'h0000;
  localparam logic [15:0] FREE_TOP = 16'hFFFF;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  // channel operating modes
  typedef enum logic [1:0] {MODE_CAPTURE, MODE_COMPARE, MODE_EDGE,
    MODE_CENTER} chan_mode_t;
  // channel control bits kept together
  typedef struct packed {
    logic irq_en;
    logic msb;
    logic msa;
    logic elsb;
    logic elsa;
  } chan_ctrl_t;
  localparam chan_ctrl_t CTRL_RESET = 5'h00;
endpackage : timer_pkg

// File: tb/pin_load.sv
/*
  External loads on the timer channel pins: tallies high cycles and
  level changes per channel. Assumes a pull-down on every released pin
  and a one-cycle tally restart from the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_load #(
  parameter int NCH = 2
) (
  // clock and tally restart
  input wire logic clock_i,
  input wire logic clr_i,
  // channel pins
  input wire logic [NCH-1:0] out_i,
  input wire logic [NCH-1:0] oe_i,
  // tallies per channel
  output logic [15:0] hi_o [NCH],
  output logic [15:0] edg_o [NCH]
);
  logic [NCH-1:0] lvl;
  logic [NCH-1:0] lvl_ff;
  // a released pin falls to the pull-down level
  assign lvl = out_i & oe_i;
  // count high cycles and level changes
  always_ff @(posedge clock_i) begin
    lvl_ff <= lvl;
    for (int i = 0; i < NCH; i++) begin
      hi_o[i] <= clr_i ? 16'h0000 : hi_o[i] + 16'(lvl[i]);
      edg_o[i] <= clr_i ? 16'h0000 : edg_o[i] + 16'(lvl[i] ^ lvl_ff[i]);
    end
  end
endmodule : pin_load
`default_nettype wire

// File: tb/timer_pwm_channels_test.sv
/*
  Self-checking bench for the timer compare/PWM channels.
  Assumes a Wishbone slave that acks every request and pin_load on the pins.
*/
`timescale 1ns/1ps
`default_nettype none
module timer_pwm_channels_test;
  import timer_pkg::*;
  localparam logic [7:0] CH0 = OFS_CH_BASE;
  localparam logic [7:0] CH1 = OFS_CH_BASE + OFS_CH_STRIDE;
  logic clock_i = 0;
  logic rstn_i = 0;
  logic cyc = 0, stb = 0, we = 0, fclk = 0, eclk = 0, clr = 0, ack, irq;
  logic [7:0] adr = 8'h00;
  logic [7:0] rd;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, dat_o;
  logic [1:0] out, oe;
  logic [15:0] hi [2];
  logic [15:0] edg [2];
  int n_fail = 0, total_checks = 0;
  // clock at 250 MHz
  always #2 clock_i = ~clock_i;
  timer_pwm_channels #(.NCH(2)) timer_pwm_channels_inst (
    .clock_i(clock_i), .rstn_i(rstn_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .fixed_clk_i(fclk),
    .ext_clk_i(eclk), .chan_out_o(out), .chan_oe_o(oe), .irq_o(irq));
  pin_load #(.NCH(2)) pin_load_inst (.clock_i(clock_i), .clr_i(clr),
    .out_i(out), .oe_i(oe), .hi_o(hi), .edg_o(edg));
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one classic cycle, held until ack is sampled
  task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    sel <= 4'h1;
    // only the watchdog ends a wait that never sees ack
    do begin
      @(posedge clock_i);
    end while (ack !== 1'b1);
    rd = dat_o[7:0];
    cyc <= 0;
    stb <= 0;
    we <= 0;
  endtask : wb
  task wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, d);
  endtask : wr
  task rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(nm, {8'h0, e}, {8'h0, rd});
  endtask : rdc
  task wv(input logic [7:0] b, input logic [15:0] v);
    wr(b + OFS_CVH, v[15:8]);
    wr(b + OFS_CVL, v[7:0]);
  endtask : wv
  // settle, then tally pins over n cycles
  task meas(input int n);
    repeat (40) @(posedge clock_i);
    clr <= 1;
    @(posedge clock_i);
    clr <= 0;
    repeat (n) @(posedge clock_i);
    #1;
  endtask : meas
  // slow edges on a count source, a quarter rate at most
  task pulses(input bit ext, input int n);
    repeat (n) begin
      repeat (4) @(posedge clock_i);
      if (ext) eclk <= 1; else fclk <= 1;
      repeat (4) @(posedge clock_i);
      eclk <= 0;
      fclk <= 0;
    end
    repeat (8) @(posedge clock_i);
  endtask : pulses
  task t_reset;
    rdc("tsc", OFS_TSC, 8'h00);
    rdc("csc0", CH0, 8'h00);
    rdc("unmapped", 8'hF0, RD_UNMAPPED);
    chk("oe", 16'h0, {14'h0, oe});
  endtask : t_reset
  task t_buffers;
    wr(CH0 + OFS_CVH, 8'h12);
    rdc("cvh half", CH0 + OFS_CVH, 8'h00);
    wr(CH0, 8'h00);
    wr(CH0 + OFS_CVL, 8'h34);
    rdc("cvl discard", CH0 + OFS_CVL, 8'h00);
    wr(CH0 + OFS_CVH, 8'h12);
    rdc("cvh pair", CH0 + OFS_CVH, 8'h12);
    rdc("cvl pair", CH0 + OFS_CVL, 8'h34);
  endtask : t_buffers
  task t_clock_sel;
    wr(OFS_CNTL, 8'h00);
    wr(OFS_TSC, 8'h10);
    pulses(1'b0, 5);
    rdc("fixed", OFS_CNTL, 8'h05);
    wr(OFS_TSC, 8'h18);
    pulses(1'b1, 3);
    rdc("ext", OFS_CNTL, 8'h08);
    wr(OFS_TSC, 8'h00);
    pulses(1'b0, 2);
    rdc("none", OFS_CNTL, 8'h08);
  endtask : t_clock_sel
  task t_edge;
    wr(OFS_MODH, 8'h00);
    wr(OFS_MODL, 8'h09);
    rdc("mod", OFS_MODL, 8'h09);
    wr(CH0, 8'h28);
    wr(CH1, 8'h14);
    wv(CH0, 16'h0003);
    wv(CH1, 16'h0005);
    wr(OFS_CNTL, 8'h00);
    wr(OFS_TSC, 8'h08);
    meas(40);
    chk("edge hi", 16'h000C, hi[0]);
    chk("toggles", 16'h0004, edg[1]);
    wv(CH1, 16'h0005);
    rdc("cv running", CH1 + OFS_CVL, 8'h05);
    wr(CH0, 8'h2C);
    meas(40);
    chk("edge inv", 16'h001C, hi[0]);
    wr(CH0, 8'h28);
    wv(CH0, 16'h0000);
    meas(40);
    chk("edge 0%", 16'h0000, hi[0]);
    wv(CH0, 16'h000A);
    meas(40);
    chk("edge 100%", 16'h0028, hi[0]);
  endtask : t_edge
  task t_flag;
    wr(OFS_TSC, 8'h00);
    wr(CH1, 8'h54);
    repeat (3) @(posedge clock_i);
    chk("irq on", 16'h1, {15'h0, irq});
    rdc("flag set", CH1, 8'hD4);
    wr(CH1, 8'h54);
    repeat (3) @(posedge clock_i);
    chk("irq off", 16'h0, {15'h0, irq});
    rdc("flag clr", CH1, 8'h54);
  endtask : t_flag
  task t_center;
    rdc("ovf pre", OFS_TSC, 8'h80);
    wr(OFS_TSC, 8'h20);
    rdc("ovf clr", OFS_TSC, 8'h20);
    wr(OFS_MODH, 8'h00);
    wr(OFS_MODL, 8'h08);
    wr(CH0, 8'h28);
    wr(CH1, 8'h28);
    wv(CH0, 16'h0003);
    wv(CH1, 16'h0000);
    wr(OFS_CNTL, 8'h00);
    wr(OFS_TSC, 8'h28);
    meas(32);
    chk("ctr hi", 16'h000C, hi[0]);
    chk("ctr zero", 16'h0000, hi[1]);
    rdc("ovf", OFS_TSC, 8'hA8);
    wr(CH0, 8'h2C);
    meas(32);
    chk("ctr inv", 16'h0014, hi[0]);
    wr(CH0, 8'h28);
    wv(CH0, 16'h0009);
    wv(CH1, 16'h8003);
    meas(32);
    chk("ctr 100%", 16'h0020, hi[0]);
    chk("ctr neg", 16'h0000, hi[1]);
  endtask : t_center
  // watchdog
  initial begin
    #80000;
    n_fail++;
    report_and_stop;
  end
  initial begin
    repeat (6) @(posedge clock_i);
    rstn_i <= 1;
    t_reset;
    t_buffers;
    t_clock_sel;
    t_edge;
    t_flag;
    t_center;
    // reset again mid-run: all control and pins back to idle
    rstn_i <= 0;
    repeat (2) @(posedge clock_i);
    rstn_i <= 1;
    t_reset;
    report_and_stop;
  end
endmodule : timer_pwm_channels_test
`default_nettype wire
